// ### cpu_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Processor side: register bus master with access routines
module cpu_bus_model
   import nv_ctrl_pkg::*;
(
   input wire logic aclk,
   output logic awvalid,
   input wire logic awready,
   output logic [AXI_AW-1:0] awaddr,
   output logic wvalid,
   input wire logic wready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   input wire logic bvalid,
   output logic bready,
   input wire logic [1:0] bresp,
   output logic arvalid,
   input wire logic arready,
   output logic [AXI_AW-1:0] araddr,
   input wire logic rvalid,
   output logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp
);
   // Bus idle at time zero
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, wdata, araddr} = '0;
      wstrb = 4'hf;
   end

   // One write; released payload is inverted so stale values never look valid
   task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      fork
         begin
            @(posedge aclk iff awready);
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         begin
            @(posedge aclk iff wready);
            wvalid <= 1'b0;
            wdata <= ~d;
         end
      join
      @(posedge aclk iff bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask : wr

   // One read, data taken at the edge where rvalid is sampled
   task automatic rd(input logic [AXI_AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge aclk iff arready);
      arvalid <= 1'b0;
      araddr <= ~a;
      @(posedge aclk iff rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd

   // Poll the busy flag until programming has ended
   task automatic wait_idle();
      logic [31:0] v;
      logic [1:0] r;
      v = 32'h2;
      while (v[BIT_START] !== 1'b0) begin
         rd(OFF_CTRL, v, r);
      end
   endtask : wait_idle

   // Programming sequence: mode, address, data, arm, then start
   task automatic prog(input logic [1:0] m, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      logic [31:0] c;
      logic [1:0] r;
      wait_idle();
      c = {26'h0, m, 4'h0};
      wr(OFF_CTRL, c, r);
      wr(OFF_ADDR_HI, {31'h0, a[8]}, r);
      wr(OFF_ADDR_LO, {24'h0, a[7:0]}, r);
      wr(OFF_DATA, {24'h0, d}, r);
      wr(OFF_CTRL, c | 32'h4, r);
      wr(OFF_CTRL, c | 32'h6, r);
   endtask : prog

   // Byte read: idle, address, strobe, then data register
   task automatic read_byte(input logic [ADDR_W-1:0] a, output logic [31:0] d);
      logic [1:0] r;
      wait_idle();
      wr(OFF_ADDR_HI, {31'h0, a[8]}, r);
      wr(OFF_ADDR_LO, {24'h0, a[7:0]}, r);
      wr(OFF_CTRL, 32'h1, r);
      rd(OFF_DATA, d, r);
   endtask : read_byte
endmodule : cpu_bus_model
`default_nettype wire

// ### nv_array.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Byte array with registered read and self-applying program ops
module nv_array
   import nv_ctrl_pkg::*;
(
   input wire logic aclk,
   input wire logic ce,
   input wire logic rd_en,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [DATA_W-1:0] rd_data,
   input wire logic prog_en,
   input wire mem_op_s op
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // Apply the finished programming operation
   always_ff @(posedge aclk) begin
      if (ce && prog_en) begin
         case (op.mode)
            MODE_ATOMIC: mem[op.addr] <= op.data;
            MODE_ERASE: mem[op.addr] <= ERASED_BYTE;
            MODE_WRITE: mem[op.addr] <= mem[op.addr] & op.data;
            default: ;
         endcase
      end
   end

   // Registered single-byte read
   always_ff @(posedge aclk) begin
      if (ce && rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule : nv_array
`default_nettype wire

// ### nv_byte_access_ctrl.sv
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Byte access controller for the on-chip nonvolatile array
module nv_byte_access_ctrl
   import nv_ctrl_pkg::*;
#(
   parameter logic [TIMER_W-1:0] ATOMIC_TICKS = TIMER_W'(ATOMIC_CYCLES),
   parameter logic [TIMER_W-1:0] SPLIT_TICKS = TIMER_W'(SPLIT_CYCLES)
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic awvalid,
   output logic awready,
   input wire logic [AXI_AW-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [AXI_AW-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic ready_irq,
   output logic cpu_stall
);
   // ==========================================================
   // Helpers
   function automatic reg_sel_e decode(input logic [AXI_AW-1:0] a);
      case (a)
         OFF_CTRL: decode = SEL_CTRL;
         OFF_DATA: decode = SEL_DATA;
         OFF_ADDR_LO: decode = SEL_ADDR_LO;
         OFF_ADDR_HI: decode = SEL_ADDR_HI;
         default: decode = SEL_NONE;
      endcase
   endfunction : decode

   // ==========================================================
   // State
   logic aw_got_r, w_got_r;
   logic [AXI_AW-1:0] aw_addr_r;
   logic [7:0] w_byte_r;
   logic w_lane_r;
   logic [DATA_W-1:0] data_r;
   logic [ADDR_W-1:0] addr_r;
   prog_mode_e mode_r;
   logic irq_en_r;
   logic arm_r;
   logic [STALL_W-1:0] arm_cnt_r;
   logic busy_r;
   logic [STALL_W-1:0] stall_cnt_r;
   logic rd_pend_r;
   mem_op_s op_r;
   logic [DATA_W-1:0] mem_rd_data;
   logic op_done;

   // ==========================================================
   // Write decode
   logic wr_fire, wr_ok;
   reg_sel_e wr_sel;
   logic wr_ctrl, rd_go, prog_go;
   assign wr_fire = aw_got_r && w_got_r && !bvalid;
   assign wr_sel = decode(aw_addr_r);
   assign wr_ok = wr_fire && w_lane_r;
   assign wr_ctrl = wr_ok && (wr_sel == SEL_CTRL);
   // Start needs the arm window open, an idle array and a defined mode
   assign prog_go = wr_ctrl && w_byte_r[BIT_START] && arm_r && !busy_r
                    && (mode_r != MODE_RSVD) && aresetn;
   // Read strobe is refused while programming or when a start wins
   assign rd_go = wr_ctrl && w_byte_r[BIT_READ] && !busy_r && !prog_go;

   // ==========================================================
   // Write address and data capture, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         awready <= 1'b1;
         aw_addr_r <= '0;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_got_r <= 1'b1;
            awready <= 1'b0;
            aw_addr_r <= awaddr;
         end else if (wr_fire) begin
            aw_got_r <= 1'b0;
            awready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_got_r <= 1'b0;
         wready <= 1'b1;
         w_byte_r <= '0;
         w_lane_r <= 1'b0;
      end else if (ce) begin
         if (wvalid && wready) begin
            w_got_r <= 1'b1;
            wready <= 1'b0;
            w_byte_r <= wdata[7:0];
            w_lane_r <= wstrb[0];
         end else if (wr_fire) begin
            w_got_r <= 1'b0;
            wready <= 1'b1;
         end
      end
   end

   // Write response after both halves are taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (ce) begin
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else if (ce) begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= RESP_OKAY;
            case (decode(araddr))
               SEL_CTRL: rdata <= {26'h0, mode_r, irq_en_r, arm_r, busy_r, 1'b0};
               SEL_DATA: rdata <= {24'h0, data_r};
               SEL_ADDR_LO: rdata <= {24'h0, addr_r[7:0]};
               SEL_ADDR_HI: rdata <= {31'h0, addr_r[8]};
               default: begin
                  rdata <= '0;
                  rresp <= RESP_SLVERR;
               end
            endcase
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Address register, closed to writes while programming; reset still loads ADDR_RST
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr_r <= ADDR_RST;
      end else if (ce && wr_ok && !busy_r) begin
         if (wr_sel == SEL_ADDR_LO) begin
            addr_r[7:0] <= w_byte_r;
         end else if (wr_sel == SEL_ADDR_HI) begin
            addr_r[8] <= w_byte_r[0];
         end
      end
   end

   // Data register: software writes or array read result
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_r <= DATA_RST;
         rd_pend_r <= 1'b0;
      end else if (ce) begin
         rd_pend_r <= rd_go;
         if (rd_pend_r) begin
            data_r <= mem_rd_data;
         end else if (wr_ok && wr_sel == SEL_DATA) begin
            data_r <= w_byte_r;
         end
      end
   end

   // ==========================================================
   // Mode and ready enable; reset keeps mode while busy
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_en_r <= 1'b0;
         case (busy_r)
            1'b1: mode_r <= mode_r;
            default: mode_r <= MODE_ATOMIC;
         endcase
      end else if (ce && wr_ctrl) begin
         irq_en_r <= w_byte_r[BIT_IRQ_EN];
         if (!busy_r) begin
            mode_r <= prog_mode_e'(w_byte_r[MODE_LSB+1:MODE_LSB]);
         end
      end
   end

   // Arm bit with its four-cycle window
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arm_r <= 1'b0;
         arm_cnt_r <= '0;
      end else if (ce) begin
         if (wr_ctrl && w_byte_r[BIT_ARM]) begin
            arm_r <= 1'b1;
            arm_cnt_r <= ARM_WINDOW;
         end else if (arm_cnt_r != '0) begin
            arm_cnt_r <= arm_cnt_r - 1'b1;
            arm_r <= (arm_cnt_r != {{(STALL_W-1){1'b0}}, 1'b1});
         end
      end
   end

   // ==========================================================
   // Busy flag and latched operation; reset never aborts a running op
   always_ff @(posedge aclk) begin
      if (!aresetn && !ce) begin
         case (busy_r)
            1'b1: busy_r <= busy_r;
            default: busy_r <= 1'b0;
         endcase
      end else if (ce) begin
         if (op_done) begin
            busy_r <= 1'b0;
         end else if (prog_go) begin
            busy_r <= 1'b1;
         end else if (!aresetn) begin
            // Case matching lets an unknown power-up value settle to idle
            case (busy_r)
               1'b1: busy_r <= 1'b1;
               default: busy_r <= 1'b0;
            endcase
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (ce && prog_go) begin
         op_r <= '{mode: mode_r, addr: addr_r, data: data_r};
      end
   end

   // Processor stall after a read or a start
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stall_cnt_r <= '0;
         cpu_stall <= 1'b0;
      end else if (ce) begin
         if (rd_go) begin
            stall_cnt_r <= READ_STALL;
            cpu_stall <= 1'b1;
         end else if (prog_go) begin
            stall_cnt_r <= START_STALL;
            cpu_stall <= 1'b1;
         end else if (stall_cnt_r != '0) begin
            stall_cnt_r <= stall_cnt_r - 1'b1;
            cpu_stall <= (stall_cnt_r != {{(STALL_W-1){1'b0}}, 1'b1});
         end
      end
   end

   // Continuous ready request
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ready_irq <= 1'b0;
      end else if (ce) begin
         ready_irq <= irq_en_r && !busy_r;
      end
   end

   // ==========================================================
   // Timer and array
   logic timer_clr_n;
   assign timer_clr_n = aresetn || busy_r;

   prog_timer u_timer (
      .aclk(aclk),
      .ce(ce),
      .clr_n(timer_clr_n),
      .start(prog_go),
      .cycles((mode_r == MODE_ATOMIC) ? ATOMIC_TICKS : SPLIT_TICKS),
      .done(op_done)
   );

   nv_array u_array (
      .aclk(aclk),
      .ce(ce),
      .rd_en(rd_go),
      .rd_addr(addr_r),
      .rd_data(mem_rd_data),
      .prog_en(op_done),
      .op(op_r)
   );

   // ==========================================================
   // Checks
   a_arm_window: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && wr_ctrl && w_byte_r[BIT_ARM] |=> arm_r && arm_cnt_r == ARM_WINDOW)
      else $error("arm window not opened to four");
   a_arm_consistent: assert property (@(posedge aclk) disable iff (!aresetn)
      arm_r == (arm_cnt_r != 3'h0))
      else $error("arm bit disagrees with window count");
   a_start_armed: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(busy_r) |-> $past(arm_r) && $past(mode_r) != MODE_RSVD)
      else $error("programming began without arm or in reserved mode");
   a_mode_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
      busy_r && $past(busy_r) |-> $stable(mode_r))
      else $error("mode changed while busy");
   a_addr_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
      busy_r && $past(busy_r) |-> $stable(addr_r))
      else $error("address changed while busy");
   a_read_refused: assert property (@(posedge aclk) disable iff (!aresetn)
      busy_r |-> !rd_go)
      else $error("array read while busy");
   a_read_stall: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && rd_go |=> stall_cnt_r == READ_STALL && cpu_stall)
      else $error("read stall not four cycles");
   a_start_stall: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(busy_r) |-> stall_cnt_r == START_STALL && cpu_stall)
      else $error("start stall not two cycles");
   a_busy_release: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(busy_r) |-> $past(op_done))
      else $error("busy cleared before timer end");
   a_ready_level: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && irq_en_r && !busy_r ##1 ce |-> ready_irq)
      else $error("ready request missing while idle");
endmodule : nv_byte_access_ctrl
`default_nettype wire

// ### nv_byte_access_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench for the byte access controller
module nv_byte_access_ctrl_tb_top;
   import nv_ctrl_pkg::*;
   typedef struct packed {
      logic [AXI_AW-1:0] a;
      logic [31:0] w;
      logic [31:0] r;
      logic [1:0] resp;
   } row_s;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, ready_irq, cpu_stall, ce;
   logic [AXI_AW-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, val;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   int failures = 0;
   int checks = 0;
   int cycles = 0;
   int stall_cycles = 0;
   // Register write, expected read-back and expected response
   row_s rows [7] = '{'{OFF_DATA, 32'ha5, 32'ha5, RESP_OKAY},
      '{OFF_ADDR_LO, 32'h3c, 32'h3c, RESP_OKAY}, '{OFF_ADDR_HI, 32'hff, 32'h01, RESP_OKAY},
      '{OFF_CTRL, 32'h08, 32'h08, RESP_OKAY}, '{OFF_CTRL, 32'h20, 32'h20, RESP_OKAY},
      '{OFF_CTRL, 32'h00, 32'h00, RESP_OKAY}, '{10'h3f0, 32'h55, 32'h00, RESP_SLVERR}};
   logic [AXI_AW-1:0] regs [4] = '{OFF_CTRL, OFF_DATA, OFF_ADDR_LO, OFF_ADDR_HI};

   // ==========================================================
   // Clock, stall monitor and hang guard
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cycles++;
      if (cpu_stall === 1'b1) stall_cycles++;
      if (cycles == 20000) begin
         failures++;
         $display("unexpected at %0t: run did not finish", $time);
         test_done();
      end
   end

   nv_byte_access_ctrl #(.ATOMIC_TICKS(18'd20), .SPLIT_TICKS(18'd10)) uut (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .ready_irq(ready_irq), .cpu_stall(cpu_stall));

   cpu_bus_model cpu (
      .aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

   // ==========================================================
   // Comparison, reset and closing tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check

   task automatic do_reset(input int n);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (n) @(posedge aclk);
      aresetn <= 1'b1;
   endtask : do_reset

   task automatic test_done();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done

   // ==========================================================
   // Main sequence
   initial begin
      aresetn = 1'b0;
      ce = 1'b1;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      // Ordinary register accesses, unmapped address last
      foreach (rows[i]) begin
         cpu.wr(rows[i].a, rows[i].w, resp);
         check({30'h0, resp}, {30'h0, rows[i].resp});
         cpu.rd(rows[i].a, val, resp);
         check(val, rows[i].r);
         check({30'h0, resp}, {30'h0, rows[i].resp});
      end
      // Reset values
      cpu.wr(OFF_CTRL, 32'h28, resp);
      do_reset(3);
      foreach (regs[i]) begin
         cpu.rd(regs[i], val, resp);
         check(val, 32'h0);
      end
      // Ready request follows the enable while idle
      cpu.wr(OFF_CTRL, 32'h08, resp);
      repeat (2) @(posedge aclk);
      check({31'h0, ready_irq}, 32'h1);
      // Atomic programming, stall and busy refusals
      stall_cycles = 0;
      cpu.prog(2'h0, 9'h1a5, 8'h5a);
      cpu.rd(OFF_CTRL, val, resp);
      // Busy set; the start write also carried the arm bit, so its window reopens
      check(val, 32'h6);
      check(stall_cycles, 2);
      stall_cycles = 0;
      cpu.wr(OFF_ADDR_LO, 32'h00, resp);
      cpu.wr(OFF_CTRL, 32'h33, resp);
      cpu.wr(OFF_CTRL, 32'h08, resp);
      repeat (2) @(posedge aclk);
      check({31'h0, ready_irq}, 32'h0);
      cpu.rd(OFF_CTRL, val, resp);
      check(val, 32'h0a);
      cpu.rd(OFF_ADDR_LO, val, resp);
      check(val, 32'ha5);
      check(stall_cycles, 0);
      cpu.wait_idle();
      repeat (2) @(posedge aclk);
      check({31'h0, ready_irq}, 32'h1);
      stall_cycles = 0;
      cpu.read_byte(9'h1a5, val);
      check(val, 32'h5a);
      repeat (4) @(posedge aclk);
      check(stall_cycles, 4);
      // Erase only, then write only onto the erased byte
      cpu.prog(2'h1, 9'h1a5, 8'h00);
      cpu.read_byte(9'h1a5, val);
      check(val, {24'h0, ERASED_BYTE});
      cpu.prog(2'h2, 9'h1a5, 8'h3c);
      cpu.read_byte(9'h1a5, val);
      check(val, 32'h3c);
      // Start without arm, after the arm window, and in the reserved mode
      cpu.wr(OFF_CTRL, 32'h02, resp);
      cpu.rd(OFF_CTRL, val, resp);
      check(val, 32'h0);
      cpu.wr(OFF_CTRL, 32'h04, resp);
      repeat (6) @(posedge aclk);
      cpu.rd(OFF_CTRL, val, resp);
      check(val, 32'h0);
      cpu.wr(OFF_CTRL, 32'h06, resp);
      cpu.rd(OFF_CTRL, val, resp);
      check(val, 32'h4);
      cpu.prog(2'h3, 9'h1a5, 8'h11);
      cpu.rd(OFF_CTRL, val, resp);
      check({31'h0, val[BIT_START]}, 32'h0);
      // Clock enable low freezes the programming timer past its normal end
      cpu.prog(2'h0, 9'h0f0, 8'h99);
      ce <= 1'b0;
      repeat (30) @(posedge aclk);
      ce <= 1'b1;
      cpu.rd(OFF_CTRL, val, resp);
      check({31'h0, val[BIT_START]}, 32'h1);
      cpu.read_byte(9'h0f0, val);
      check(val, 32'h99);
      // Reset in mid-programming lets the operation finish
      cpu.prog(2'h0, 9'h00f, 8'h77);
      do_reset(3);
      cpu.rd(OFF_CTRL, val, resp);
      check({31'h0, val[BIT_START]}, 32'h1);
      cpu.read_byte(9'h00f, val);
      check(val, 32'h77);
      test_done();
   end
endmodule : nv_byte_access_ctrl_tb_top
`default_nettype wire

// ### nv_ctrl_pkg.sv
package nv_ctrl_pkg;
   // ==========================================================
   // Array geometry and bus widths
   localparam int ADDR_W = 9;
   localparam int DATA_W = 8;
   localparam int AXI_AW = 10;
   localparam int TIMER_W = 18;
   localparam int STALL_W = 3;

   // ==========================================================
   // Register indices and byte offsets
   localparam logic [7:0] IDX_CTRL = 8'h1f;
   localparam logic [7:0] IDX_DATA = 8'h20;
   localparam logic [7:0] IDX_ADDR_LO = 8'h21;
   localparam logic [7:0] IDX_ADDR_HI = 8'h22;
   localparam logic [AXI_AW-1:0] OFF_CTRL = {IDX_CTRL, 2'b00};
   localparam logic [AXI_AW-1:0] OFF_DATA = {IDX_DATA, 2'b00};
   localparam logic [AXI_AW-1:0] OFF_ADDR_LO = {IDX_ADDR_LO, 2'b00};
   localparam logic [AXI_AW-1:0] OFF_ADDR_HI = {IDX_ADDR_HI, 2'b00};

   // ==========================================================
   // Control register fields
   localparam int BIT_READ = 0;
   localparam int BIT_START = 1;
   localparam int BIT_ARM = 2;
   localparam int BIT_IRQ_EN = 3;
   localparam int MODE_LSB = 4;

   // ==========================================================
   // Reset values and array contents
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RST = 9'h000;
   localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;

   // ==========================================================
   // Timing
   localparam logic [STALL_W-1:0] ARM_WINDOW = 3'h4;
   localparam logic [STALL_W-1:0] READ_STALL = 3'h4;
   localparam logic [STALL_W-1:0] START_STALL = 3'h2;
   localparam int CLK_PERIOD_NS = 20;
   localparam int T_ATOMIC_NS = 3400000;
   localparam int T_SPLIT_NS = 1800000;
   localparam int ATOMIC_CYCLES = (T_ATOMIC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SPLIT_CYCLES = (T_SPLIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      MODE_ATOMIC = 2'h0,
      MODE_ERASE = 2'h1,
      MODE_WRITE = 2'h2,
      MODE_RSVD = 2'h3
   } prog_mode_e;

   typedef enum logic [2:0] {SEL_CTRL, SEL_DATA, SEL_ADDR_LO, SEL_ADDR_HI, SEL_NONE} reg_sel_e;

   typedef struct packed {
      prog_mode_e mode;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } mem_op_s;
endpackage : nv_ctrl_pkg

// ### prog_timer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Down-counter that times one programming operation
module prog_timer
   import nv_ctrl_pkg::*;
(
   input wire logic aclk,
   input wire logic ce,
   input wire logic clr_n,
   input wire logic start,
   input wire logic [TIMER_W-1:0] cycles,
   output logic done
);
   logic [TIMER_W-1:0] remain_r;

   // Load on start, pulse done on the last cycle
   always_ff @(posedge aclk) begin
      if (!clr_n) begin
         remain_r <= '0;
         done <= 1'b0;
      end else if (ce) begin
         done <= 1'b0;
         if (start) begin
            remain_r <= cycles;
         end else if (remain_r != '0) begin
            remain_r <= remain_r - 1'b1;
            done <= (remain_r == {{(TIMER_W-1){1'b0}}, 1'b1});
         end
      end
   end
endmodule : prog_timer
`default_nettype wire
